//--- hdl/rcg_pkg.sv
// package: constants and types of the reference clock generator
`default_nettype none
package rcg_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned DEC_W = 12;
  localparam logic [DEC_W-1:0] CTL_OFFSET = 12'h000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned DIV_W = 15;
  localparam int unsigned DIV_LSB = 16;
  localparam int unsigned DIV_MSB = 30;
  localparam int unsigned ON_BIT = 15;
  localparam int unsigned HALT_IDLE_BIT = 13;
  localparam int unsigned OE_BIT = 12;
  localparam int unsigned RUN_SLEEP_BIT = 11;
  localparam int unsigned SWITCH_BIT = 9;
  localparam int unsigned ACTIVE_BIT = 8;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_MSB = 3;
  localparam int unsigned NUM_SRC = 16;
  localparam logic [SEL_W-1:0] SEL_NO_SLEEP_A = 4'h0;
  localparam logic [SEL_W-1:0] SEL_NO_SLEEP_B = 4'h1;
  localparam logic [DIV_W-1:0] DIV_ZERO = 15'h0000;
  localparam logic [DIV_W-1:0] DIV_ONE = 15'h0001;
  // ---------------------------------------------------------------
  // ahb-lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // ---------------------------------------------------------------
  // divider switch handshake
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    SW_IDLE = 1'b0,
    SW_PEND = 1'b1
  } rcg_sw_state_t;
endpackage : rcg_pkg
`default_nettype wire

//--- hdl/rcg_src_pick.sv
// module: selects one reference source and finds its rising edges
`default_nettype none
module rcg_src_pick #(
  parameter int unsigned NSRC = 16,
  parameter int unsigned SW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NSRC-1:0] src_clk,
  input wire logic [SW-1:0] sel,
  output logic src_level,
  output logic src_rise
);
  import rcg_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic lvl;
    logic prev;
  } rcg_pick_st_t;
  rcg_pick_st_t s_q;
  rcg_pick_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.lvl = src_clk[sel];
    s_d.prev = s_q.lvl;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign src_level = s_q.lvl;
  assign src_rise = s_q.lvl & ~s_q.prev;
endmodule : rcg_src_pick
`default_nettype wire

//--- hdl/rcg_divider.sv
// module: divides the selected source by twice the divide value, and passes it through when the divide value is zero
`default_nettype none
module rcg_divider #(
  parameter int unsigned DW = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic src_level,
  input wire logic src_rise,
  input wire logic [DW-1:0] div_val,
  output logic clk_out,
  output logic period_end
);
  import rcg_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic out;
    logic pend;
  } rcg_div_st_t;
  rcg_div_st_t s_q;
  rcg_div_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.pend = 1'b0;
    if (!run) begin
      // stopped output rests low and the count clears, so a restart begins with a full low phase; a stop cuts a high phase short
      s_d.cnt = '0;
      s_d.out = 1'b0;
    end else if (div_val == DIV_ZERO) begin
      s_d.out = src_level;
      s_d.pend = src_rise;
    end else if (src_rise) begin
      if (s_q.cnt == DW'(div_val - DIV_ONE)) begin
        s_d.cnt = '0;
        s_d.out = ~s_q.out;
        s_d.pend = s_q.out;
      end else begin
        s_d.cnt = DW'(s_q.cnt + DIV_ONE);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.out;
  assign period_end = s_q.pend;
endmodule : rcg_divider
`default_nettype wire

//--- hdl/rcg_top.sv
// module: reference clock generator with its ahb-lite control register
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
module rcg_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [rcg_pkg::NUM_SRC-1:0] src_clk,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  output logic ref_clock_out_pin
);
  import rcg_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic on;
    logic halt_in_idle;
    logic oe;
    logic run_during_sleep;
    logic [DIV_W-1:0] ref_divide_value;
    logic [DIV_W-1:0] div_act;
    logic [SEL_W-1:0] ref_source_select;
    rcg_sw_state_t sw;
    logic wr_pend;
    logic hit;
    logic [31:0] rdata;
    logic pin;
  } rcg_top_st_t;
  rcg_top_st_t s_q;
  rcg_top_st_t s_d;

  logic src_level;
  logic src_rise;
  logic div_clk;
  logic period_end;
  logic running;
  logic run_n;
  logic addr_ok;
  logic addr_hit;
  logic [31:0] ctl_rd;

  // ---------------------------------------------------------------
  // run gating
  // ---------------------------------------------------------------
  function automatic logic run_ok(input logic on, input logic hi,
                                  input logic rs, input logic [SEL_W-1:0] sel);
    logic sleep_stop;
    sleep_stop = 1'b0;
    // sources 0 and 1 stop in sleep whatever the run-in-sleep bit says
    if (sel == SEL_NO_SLEEP_A || sel == SEL_NO_SLEEP_B) begin
      sleep_stop = sleep_mode;
    end else begin
      sleep_stop = sleep_mode & ~rs;
    end
    run_ok = on & ~(idle_mode & hi) & ~sleep_stop;
  endfunction : run_ok

  assign running = run_ok(s_q.on, s_q.halt_in_idle, s_q.run_during_sleep,
                          s_q.ref_source_select);
  assign run_n = run_ok(s_d.on, s_d.halt_in_idle, s_d.run_during_sleep,
                        s_d.ref_source_select);

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  rcg_src_pick #(
    .NSRC(NUM_SRC),
    .SW(SEL_W)
  ) u_pick (
    .clk(clk),
    .rst(rst),
    .src_clk(src_clk),
    .sel(s_q.ref_source_select),
    .src_level(src_level),
    .src_rise(src_rise)
  );

  rcg_divider #(
    .DW(DIV_W)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .run(running),
    .src_level(src_level),
    .src_rise(src_rise),
    .div_val(s_q.div_act),
    .clk_out(div_clk),
    .period_end(period_end)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // nonseq and seq both carry bit 1; idle and busy never start a transfer
  assign addr_ok = hsel & hready & htrans[1];
  assign addr_hit = (haddr[DEC_W-1:0] == CTL_OFFSET);

  // read view built from the next state so a read straight after a
  // write sees the written value
  always_comb begin
    ctl_rd = CTL_RESET;
    ctl_rd[DIV_MSB:DIV_LSB] = s_d.ref_divide_value;
    ctl_rd[ON_BIT] = s_d.on;
    ctl_rd[HALT_IDLE_BIT] = s_d.halt_in_idle;
    ctl_rd[OE_BIT] = s_d.oe;
    ctl_rd[RUN_SLEEP_BIT] = s_d.run_during_sleep;
    ctl_rd[SWITCH_BIT] = (s_d.sw == SW_PEND);
    ctl_rd[ACTIVE_BIT] = run_n;
    ctl_rd[SEL_MSB:SEL_LSB] = s_d.ref_source_select;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // switch completes at a period boundary, or at once when stopped
    case (s_q.sw)
      SW_IDLE: begin
        s_d.sw = SW_IDLE;
      end
      SW_PEND: begin
        if (period_end || !running) begin
          s_d.div_act = s_q.ref_divide_value;
          s_d.sw = SW_IDLE;
        end
      end
      default: begin
        s_d.sw = SW_IDLE;
      end
    endcase
    // software write in data phase; a new request wins over completion
    if (s_q.wr_pend && s_q.hit) begin
      s_d.on = hwdata[ON_BIT];
      s_d.halt_in_idle = hwdata[HALT_IDLE_BIT];
      s_d.oe = hwdata[OE_BIT];
      s_d.run_during_sleep = hwdata[RUN_SLEEP_BIT];
      s_d.ref_divide_value = hwdata[DIV_MSB:DIV_LSB];
      s_d.ref_source_select = hwdata[SEL_MSB:SEL_LSB];
      if (hwdata[SWITCH_BIT]) begin
        s_d.sw = SW_PEND;
      end
    end
    // with the module off the divide value loads without a switch
    if (!s_d.on) begin
      s_d.div_act = s_d.ref_divide_value;
    end
    s_d.wr_pend = addr_ok & hwrite;
    s_d.hit = addr_ok & addr_hit;
    if (addr_ok && !hwrite && addr_hit) begin
      s_d.rdata = ctl_rd;
    end else begin
      s_d.rdata = RDATA_ZERO;
    end
    s_d.pin = s_q.oe & running & div_clk;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = s_q.rdata;
  assign ref_clock_out_pin = s_q.pin;
endmodule : rcg_top
`default_nettype wire

//--- verification/rcg_monitor.sv
// checker: bus and pin properties of the reference clock generator
`default_nettype none
module rcg_monitor import rcg_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [NUM_SRC-1:0] src_clk,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire logic ref_clock_out_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // shadow of the control word, written like the register itself
  // ---------------------------------------------------------------
  logic wr_q;
  logic [31:0] ctl_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'h0;
      ctl_q <= CTL_RESET;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == CTL_OFFSET;
      ctl_q <= wr_q ? hwdata : ctl_q;
    end
  end
  sequence rd_s;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence rd_bad_s;
    rd_s ##0 haddr[11:0] != CTL_OFFSET;
  endsequence
  // three cycles covers the one-cycle pin latency
  property off_p(c);
    c [*3] |-> !ref_clock_out_pin;
  endproperty
  no_wait_a: assert property (hreadyout && hresp == HRESP_OKAY) else $error("bad bus answer");
  unused_zero_a: assert property (hrdata[31] == 1'h0 && hrdata[14] == 1'h0
    && hrdata[10] == 1'h0 && hrdata[7:4] == 4'h0) else $error("unused bit set");
  rd_quiet_a: assert property (hrdata != 32'h0 |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data outside data phase");
  unmapped_a: assert property (rd_bad_s |=> hrdata == 32'h0) else $error("unmapped read");
  oe_off_a: assert property (off_p(!ctl_q[12])) else $error("pin without oe");
  mod_off_a: assert property (off_p(!ctl_q[15])) else $error("pin while off");
  idle_halt_a: assert property (off_p(idle_mode && ctl_q[13])) else $error("idle");
  sleep_stop_a: assert property (off_p(sleep_mode && !ctl_q[11])) else $error("sleep");
  sel_sleep_a: assert property (off_p(sleep_mode && ctl_q[3:1] == 3'h0))
    else $error("low source ran in sleep");
endmodule : rcg_monitor
bind rcg_top rcg_monitor mon_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .src_clk(src_clk),
  .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ref_clock_out_pin(ref_clock_out_pin));
`default_nettype wire

//--- verification/tb_top.sv
// testbench: register and pin scenarios of the reference clock generator
`default_nettype none
module tb_top import rcg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, rd_q = 1'h0;
  logic idle_mode = 1'h0, sleep_mode = 1'h0, hreadyout, hresp, ref_clock_out_pin;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [NUM_SRC-1:0] src_clk = 16'h0;
  logic [31:0] exp_q[$];
  logic [31:0] last_c = 32'h0;
  logic [31:0] ctls[8] = '{32'h0001_9002, 32'h0001_8002, 32'h0001_1002, 32'h0001_b002,
    32'h0001_9002, 32'h0001_9002, 32'h0001_9802, 32'h0001_9801};
  logic [1:0] modes[8] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  int n_fail = 0;
  int total_checks = 0;
  wire hready = hreadyout;
  always #2 clk = ~clk;
  // every source rises once per two clocks
  always @(posedge clk) src_clk <= ~src_clk;
  rcg_top dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .src_clk(src_clk), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .ref_clock_out_pin(ref_clock_out_pin));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask : check
  task automatic end_of_test;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic wait_rdy;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_of_test();
    end
  endtask : wait_rdy
  // waits for a falling pin edge, which follows a divider period end
  task automatic wait_fall;
    logic p;
    int n = 0;
    do begin
      p = ref_clock_out_pin;
      @(posedge clk);
      n++;
    end while (!(p && !ref_clock_out_pin) && n < 40);
    if (!(p && !ref_clock_out_pin)) begin
      n_fail++;
      end_of_test();
    end
  endtask : wait_fall
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(a, 1'h0, $urandom);
  endtask : rd
  task automatic cnt(input int cyc, input int lo, input int hi);
    logic p;
    int k = 0;
    p = ref_clock_out_pin;
    repeat (cyc) begin
      @(posedge clk);
      k += int'(ref_clock_out_pin && !p);
      p = ref_clock_out_pin;
    end
    check(32'(k >= lo && k <= hi), 32'h1);
  endtask : cnt
  task automatic row(input logic [31:0] c, input logic [1:0] m);
    logic run;
    run = c[15] && !(m[1] && c[13]) && !(m[0] && (!c[11] || c[3:1] == 3'h0));
    idle_mode <= m[1];
    sleep_mode <= m[0];
    // switch off with unchanged fields, so select never changes while active
    bus(32'h0, 1'h1, last_c & 32'hffff_7fff);
    bus(32'h0, 1'h1, c & 32'hffff_7fff);
    bus(32'h0, 1'h1, c);
    last_c = c;
    rd(32'h0, c | {23'h0, run, 8'h0});
    repeat (6) @(posedge clk);
    cnt(40, run && c[12] ? 9 : 0, run && c[12] ? 11 : 0);
  endtask : row
  // results appear in the read data phase
  always @(posedge clk) begin
    if (rd_q) check(hrdata, exp_q.pop_front());
    rd_q <= hsel && hready && htrans[1] && !hwrite;
  end
  initial begin
    void'($urandom(32'h64c4efa8));
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(32'h0, CTL_RESET);
    bus(32'h0, 1'h1, 32'hffff_7fff);
    rd(32'h0, 32'h7fff_380f);
    bus($urandom | 32'h4, 1'h1, 32'h0);
    rd($urandom | 32'h4, 32'h0);
    rd(32'h0, 32'h7fff_380f);
    foreach (ctls[i]) row(ctls[i], modes[i]);
    idle_mode <= 1'h0;
    sleep_mode <= 1'h0;
    bus(32'h0, 1'h1, last_c & 32'hffff_7fff);
    bus(32'h0, 1'h1, 32'h0003_1002);
    bus(32'h0, 1'h1, 32'h0003_9002);
    cnt(48, 3, 5);
    // divide changes only while halted in idle, so the request is not active
    idle_mode <= 1'h1;
    bus(32'h0, 1'h1, 32'h0003_b002);
    rd(32'h0, 32'h0003_b002);
    bus(32'h0, 1'h1, 32'h0001_b002);
    idle_mode <= 1'h0;
    cnt(48, 3, 5);
    // a period has just ended, so the switch stays pending for the read
    wait_fall();
    bus(32'h0, 1'h1, 32'h0001_b202);
    rd(32'h0, 32'h0001_b302);
    repeat (20) @(posedge clk);
    cnt(48, 11, 13);
    rd(32'h0, 32'h0001_b102);
    repeat (2) @(posedge clk);
    check(32'(exp_q.size()), 32'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
